/* flame_pulse_qualifier.v */
// Eight-zone flame-pulse qualifier with AXI4-Lite register access.
// Assumes switch, presence and pulse pins are asynchronous to aclk and
// that the switches are settled before reset is released.
//
// Contract
// (RL1) Enabled zone without detector signals fault
// (RL2) Disabled zone alarms, no self-test, no fault
// (RL3) Detector sends pulses only when IR enables
// (RL4) Count pulses per gate, judge at gate end
// (RL5) Gate programmable in 31.25 ms steps
// (RL6) Gate length is sum of switch weights
// (RL7) No gate switch gives minimum 31.25 ms
// (RL8) Count setting is sum of 8,4,2,1
// (RL9) Count below two becomes two
// (RL10) Base count ranges 2 to 15
// (RL11) Short gate uses count directly
// (RL12) Long gate multiplies count by factor
// (RL13) Fire after threshold met in consecutive gates
// (RL14) Consecutive setting summed, minimum two
// (RL15) Switches settled before power, sampled once
// (RL16) Failed gate clears consecutive counter
// (RL17) Long-gate factors are configurable constants
// (RL18) Per-zone counters, one shared gate timebase
`timescale 1ns/1ns
`default_nettype none
`include "flame_qual_defs.vh"

module flame_pulse_qualifier #(
	parameter [`STEP_CNT_W-1:0] STEP_CYCLES = `STEP_CYCLES,
	parameter [2:0] FACTOR_0P5S = `FACTOR_0P5S, // [RL17]
	parameter [2:0] FACTOR_1S = `FACTOR_1S,
	parameter [2:0] FACTOR_2S = `FACTOR_2S,
	parameter [2:0] FACTOR_4S = `FACTOR_4S
) (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// AXI4-Lite write address and data
	input wire [5:0] s_axil_awaddr,
	input wire s_axil_awvalid,
	output reg s_axil_awready,
	input wire [31:0] s_axil_wdata,
	input wire [3:0] s_axil_wstrb,
	input wire s_axil_wvalid,
	output reg s_axil_wready,
	// AXI4-Lite write response
	output reg [1:0] s_axil_bresp,
	output reg s_axil_bvalid,
	input wire s_axil_bready,
	// AXI4-Lite read
	input wire [5:0] s_axil_araddr,
	input wire s_axil_arvalid,
	output reg s_axil_arready,
	output reg [31:0] s_axil_rdata,
	output reg [1:0] s_axil_rresp,
	output reg s_axil_rvalid,
	input wire s_axil_rready,
	// Configuration switches
	input wire [7:0] gate_len_sw,
	input wire [3:0] count_sw,
	input wire [3:0] consec_sw,
	input wire [7:0] zone_enable_sw,
	// Detector side
	input wire [7:0] flame_pulse,
	input wire [7:0] detector_present,
	// Results
	output wire [7:0] zone_fire,
	output reg [7:0] zone_fault_ff,
	output reg [7:0] optical_path_self_test_mask_ff,
	output reg irq_ff
);

localparam SYNC_W = 40;

// Synchroniser stages and agreement filter
reg [SYNC_W-1:0] sync1_ff;
reg [SYNC_W-1:0] sync2_ff;
reg [SYNC_W-1:0] sync3_ff;
reg [SYNC_W-1:0] filt_ff;
reg [7:0] pulse_prev_ff;
wire [SYNC_W-1:0] pin_bus;
wire [7:0] pulse_rise;

// Captured configuration
reg [2:0] cap_cnt_ff;
reg cfg_loaded_ff;
reg [7:0] gate_cfg_ff;
reg [3:0] count_cfg_ff;
reg [3:0] consec_cfg_ff;
reg [7:0] zone_en_ff;

// Derived settings
reg [7:0] gate_steps;
reg [3:0] base_count;
reg [3:0] consec_target;
reg [2:0] factor;
reg [`THR_W-1:0] threshold;

// Shared timebase
reg [`STEP_CNT_W-1:0] step_cnt_ff;
reg [7:0] gate_cnt_ff;
reg gate_end_ff;
wire active;

// Registers
reg [1:0] ctrl_ff;
reg [15:0] irq_stat_ff;
reg [15:0] irq_mask_ff;
reg [7:0] fire_prev_ff;
reg [7:0] fault_prev_ff;
reg [15:0] irq_events;
reg aw_held_ff;
reg w_held_ff;
reg [5:0] awaddr_ff;
reg [31:0] wdata_ff;
reg [3:0] wstrb_ff;
reg [31:0] rd_mux;
reg rd_ok;
wire [3:0] wr_idx;
wire [3:0] rd_idx;
wire do_write;
wire do_read;

assign pin_bus = {zone_enable_sw, consec_sw, count_sw, gate_len_sw,
	detector_present, flame_pulse};

// Three-stage sync per pin; value moves once stages two and three agree
genvar gi;
generate
	for (gi = 0; gi < SYNC_W; gi = gi + 1) begin : g_sync
		always @(posedge aclk) begin
			if (!aresetn) begin
				sync1_ff[gi] <= 1'b0;
				sync2_ff[gi] <= 1'b0;
				sync3_ff[gi] <= 1'b0;
				filt_ff[gi] <= 1'b0;
			end else begin
				sync1_ff[gi] <= pin_bus[gi];
				sync2_ff[gi] <= sync1_ff[gi];
				sync3_ff[gi] <= sync2_ff[gi];
				if (sync2_ff[gi] == sync3_ff[gi])
					filt_ff[gi] <= sync3_ff[gi];
			end
		end
	end
endgenerate

// Pulse edge detection on the filtered detector lines
always @(posedge aclk) begin
	if (!aresetn)
		pulse_prev_ff <= 8'h00;
	else
		pulse_prev_ff <= filt_ff[7:0];
end
assign pulse_rise = filt_ff[7:0] & ~pulse_prev_ff; // [RL3]

// Switches are read once after release, when the filter has settled
always @(posedge aclk) begin
	if (!aresetn) begin
		cap_cnt_ff <= 3'h0;
		cfg_loaded_ff <= 1'b0;
		gate_cfg_ff <= 8'h00;
		count_cfg_ff <= 4'h0;
		consec_cfg_ff <= 4'h0;
		zone_en_ff <= 8'h00;
	end else if (!cfg_loaded_ff) begin
		if (cap_cnt_ff == `CAPTURE_DELAY) begin
			cfg_loaded_ff <= 1'b1; // [RL15]
			gate_cfg_ff <= filt_ff[23:16];
			count_cfg_ff <= filt_ff[27:24];
			consec_cfg_ff <= filt_ff[31:28];
			zone_en_ff <= filt_ff[39:32];
		end else begin
			cap_cnt_ff <= cap_cnt_ff + 3'h1;
		end
	end
end

// Effective gate, count and consecutive settings
always @* begin
	gate_steps = (gate_cfg_ff == 8'h00) ? `GATE_MIN_STEPS
		: gate_cfg_ff; // [RL5] [RL6] [RL7]
	base_count = (count_cfg_ff < `MIN_COUNT) ? `MIN_COUNT
		: count_cfg_ff; // [RL8] [RL9] [RL10]
	consec_target = (consec_cfg_ff < `MIN_CONSEC) ? `MIN_CONSEC
		: consec_cfg_ff; // [RL14]
	// Highest closed upper switch picks the multiplier
	if (gate_cfg_ff[7])
		factor = FACTOR_4S; // [RL12]
	else if (gate_cfg_ff[6])
		factor = FACTOR_2S;
	else if (gate_cfg_ff[5])
		factor = FACTOR_1S;
	else if (gate_cfg_ff[4])
		factor = FACTOR_0P5S;
	else
		factor = 3'h1; // [RL11]
	threshold = {3'h0, base_count} * {4'h0, factor};
end

assign active = cfg_loaded_ff && ctrl_ff[0];

// Common 31.25 ms step and gate counters shared by every zone
always @(posedge aclk) begin
	if (!aresetn || !active) begin
		step_cnt_ff <= {`STEP_CNT_W{1'b0}};
		gate_cnt_ff <= 8'h00;
		gate_end_ff <= 1'b0;
	end else begin
		gate_end_ff <= 1'b0;
		if (step_cnt_ff == STEP_CYCLES - 1'b1) begin
			step_cnt_ff <= {`STEP_CNT_W{1'b0}};
			if (gate_cnt_ff == gate_steps - 8'h01) begin
				gate_cnt_ff <= 8'h00;
				gate_end_ff <= 1'b1; // [RL18]
			end else begin
				gate_cnt_ff <= gate_cnt_ff + 8'h01;
			end
		end else begin
			step_cnt_ff <= step_cnt_ff + 1'b1;
		end
	end
end

// Independent qualifier per zone; fire ignores the enable switch
generate
	for (gi = 0; gi < `NUM_ZONES; gi = gi + 1) begin : g_zone
		zone_qualifier u_zone (
			.aclk(aclk),
			.aresetn(aresetn),
			.active(active),
			.gate_end(gate_end_ff),
			.threshold(threshold),
			.consec_target(consec_target),
			.pulse_rise(pulse_rise[gi]),
			.fire_ff(zone_fire[gi]) // [RL2] [RL18]
		);
	end
endgenerate

// Fault and self-test eligibility follow the enable switches
always @(posedge aclk) begin
	if (!aresetn) begin
		zone_fault_ff <= 8'h00;
		optical_path_self_test_mask_ff <= 8'h00;
	end else if (cfg_loaded_ff) begin
		zone_fault_ff <= zone_en_ff & ~filt_ff[15:8]; // [RL1] [RL2]
		optical_path_self_test_mask_ff <= zone_en_ff; // [RL2]
	end
end

// Interrupt events: rising fire and rising fault per zone
always @* begin
	irq_events = {zone_fault_ff & ~fault_prev_ff,
		zone_fire & ~fire_prev_ff};
end

// AXI handshakes; address and data may arrive in either order
assign do_write = aw_held_ff && w_held_ff && !s_axil_bvalid;
assign do_read = s_axil_arvalid && s_axil_arready;
assign wr_idx = awaddr_ff[`ADDR_IDX_MSB:`ADDR_IDX_LSB];
assign rd_idx = s_axil_araddr[`ADDR_IDX_MSB:`ADDR_IDX_LSB];

// Read data selection; unmapped words answer SLVERR with zero data
always @* begin
	rd_ok = 1'b1;
	case (rd_idx)
		`REG_CTRL: rd_mux = {30'h0, ctrl_ff};
		`REG_CONFIG: rd_mux = {8'h00, zone_en_ff, consec_cfg_ff,
			count_cfg_ff, gate_cfg_ff};
		`REG_ZONE_STAT: rd_mux = {7'h00, cfg_loaded_ff, filt_ff[15:8],
			zone_fault_ff, zone_fire};
		`REG_IRQ_STAT: rd_mux = {16'h0000, irq_stat_ff};
		`REG_IRQ_MASK: rd_mux = {16'h0000, irq_mask_ff};
		`REG_THRESH: rd_mux = {20'h00000, consec_target, 1'b0,
			threshold};
		default: begin
			rd_mux = 32'h00000000;
			rd_ok = 1'b0;
		end
	endcase
end

// Bus slave and software registers
always @(posedge aclk) begin
	if (!aresetn) begin
		s_axil_awready <= 1'b0;
		s_axil_wready <= 1'b0;
		s_axil_bvalid <= 1'b0;
		s_axil_bresp <= `RESP_OKAY;
		s_axil_arready <= 1'b0;
		s_axil_rvalid <= 1'b0;
		s_axil_rresp <= `RESP_OKAY;
		s_axil_rdata <= 32'h00000000;
		aw_held_ff <= 1'b0;
		w_held_ff <= 1'b0;
		awaddr_ff <= 6'h00;
		wdata_ff <= 32'h00000000;
		wstrb_ff <= 4'h0;
		ctrl_ff <= `CTRL_RESET;
		irq_mask_ff <= `IRQ_MASK_RESET;
		irq_stat_ff <= 16'h0000;
		fire_prev_ff <= 8'h00;
		fault_prev_ff <= 8'h00;
		irq_ff <= 1'b0;
	end else begin
		fire_prev_ff <= zone_fire;
		fault_prev_ff <= zone_fault_ff;
		// Ready only while the holding slot is free
		s_axil_awready <= !aw_held_ff && !s_axil_awready;
		s_axil_wready <= !w_held_ff && !s_axil_wready;
		if (s_axil_awvalid && s_axil_awready) begin
			aw_held_ff <= 1'b1;
			awaddr_ff <= s_axil_awaddr;
		end
		if (s_axil_wvalid && s_axil_wready) begin
			w_held_ff <= 1'b1;
			wdata_ff <= s_axil_wdata;
			wstrb_ff <= s_axil_wstrb;
		end
		if (do_write) begin
			aw_held_ff <= 1'b0;
			w_held_ff <= 1'b0;
			s_axil_bvalid <= 1'b1;
			s_axil_bresp <= `RESP_OKAY;
			case (wr_idx)
				`REG_CTRL: if (wstrb_ff[0])
					ctrl_ff <= wdata_ff[1:0];
				`REG_IRQ_MASK: begin
					if (wstrb_ff[0])
						irq_mask_ff[7:0] <= wdata_ff[7:0];
					if (wstrb_ff[1])
						irq_mask_ff[15:8] <= wdata_ff[15:8];
				end
				`REG_CONFIG, `REG_ZONE_STAT, `REG_IRQ_STAT,
				`REG_THRESH: ;
				default: s_axil_bresp <= `RESP_SLVERR;
			endcase
		end else if (s_axil_bvalid && s_axil_bready) begin
			s_axil_bvalid <= 1'b0;
		end
		// One read in flight; arready drops while an answer waits
		s_axil_arready <= !s_axil_rvalid && !s_axil_arready;
		if (do_read) begin
			s_axil_rvalid <= 1'b1;
			s_axil_rdata <= rd_mux;
			s_axil_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axil_rvalid && s_axil_rready) begin
			s_axil_rvalid <= 1'b0;
		end
		// Read clears status; a new event in the same cycle survives
		if (do_read && (rd_idx == `REG_IRQ_STAT))
			irq_stat_ff <= irq_events;
		else
			irq_stat_ff <= irq_stat_ff | irq_events;
		irq_ff <= |((irq_stat_ff | irq_events) & irq_mask_ff &
			~((do_read && (rd_idx == `REG_IRQ_STAT)) ?
			irq_stat_ff & ~irq_events : 16'h0000));
	end
end

endmodule
`default_nettype wire

/* flame_qual_defs.vh */
// Constants for the flame-pulse qualifier: register map, field layout,
// reset values and timing. Included by the design files; definitions only.
`ifndef FLAME_QUAL_DEFS_VH
`define FLAME_QUAL_DEFS_VH

// Timing, 100 MHz system clock
`define CLK_PERIOD_NS 10
`define BASE_STEP_NS 31250000
// 31.25 ms step in 10 ns clocks, sized to the step counter
`define STEP_CYCLES 22'h2FAF08
`define STEP_CNT_W 22

// Zones and widths
`define NUM_ZONES 8
`define GATE_SW_W 8
`define NIBBLE_W 4
`define THR_W 7
`define PCNT_W 7

// Substitutes for too-small settings
`define GATE_MIN_STEPS 8'h01
`define MIN_COUNT 4'h2
`define MIN_CONSEC 4'h2
// Gate length of 0.5 s or more is any of the upper four switches
`define GATE_LONG_MSB 7
`define GATE_LONG_LSB 4

// Long-gate count multipliers, selected by the highest upper switch
`define FACTOR_0P5S 3'h2
`define FACTOR_1S 3'h4
`define FACTOR_2S 3'h5
`define FACTOR_4S 3'h5

// Edges after release before the filter holds the switch levels
`define CAPTURE_DELAY 3'h4

// Register word indices; the byte address is four times the index
`define REG_CTRL 4'h0
`define REG_CONFIG 4'h1
`define REG_ZONE_STAT 4'h2
`define REG_IRQ_STAT 4'h3
`define REG_IRQ_MASK 4'h4
`define REG_THRESH 4'h5
`define ADDR_IDX_MSB 5
`define ADDR_IDX_LSB 2

// Reset values
`define CTRL_RESET 2'h1
`define IRQ_MASK_RESET 16'h0000

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* zone_qualifier.v */
// One zone's pulse counter and consecutive-gate counter.
// Assumes gate_end is a one-cycle pulse shared by all zones and that
// pulse_rise is already synchronised to aclk.
`timescale 1ns/1ns
`default_nettype none
`include "flame_qual_defs.vh"

module zone_qualifier (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Common gate timing and settings
	input wire active,
	input wire gate_end,
	input wire [`THR_W-1:0] threshold,
	input wire [`NIBBLE_W-1:0] consec_target,
	// Detector pulses
	input wire pulse_rise,
	// Result
	output reg fire_ff
);

reg [`PCNT_W-1:0] pulse_cnt_ff;
reg [`NIBBLE_W-1:0] consec_ff;
reg [`PCNT_W-1:0] nxt_pulse_cnt;
reg [`NIBBLE_W-1:0] nxt_consec;
reg nxt_fire;
reg met;

// Gate judgement; a pulse landing on gate_end still counts for this gate
always @* begin
	nxt_pulse_cnt = pulse_cnt_ff;
	nxt_consec = consec_ff;
	nxt_fire = fire_ff;
	met = 1'b0;
	if (!active) begin
		nxt_pulse_cnt = {`PCNT_W{1'b0}};
		nxt_consec = {`NIBBLE_W{1'b0}};
		nxt_fire = 1'b0;
	end else if (gate_end) begin
		met = ({1'b0, pulse_cnt_ff} + {{`PCNT_W{1'b0}}, pulse_rise})
			>= {1'b0, threshold}; // [RL4]
		nxt_pulse_cnt = {`PCNT_W{1'b0}};
		if (met) begin
			// Saturate: a run longer than the target keeps fire
			if (consec_ff != consec_target)
				nxt_consec = consec_ff + 4'h1;
		end else begin
			nxt_consec = {`NIBBLE_W{1'b0}}; // [RL16]
		end
		// Fifth bit keeps a run at target 15 from wrapping to zero
		nxt_fire = met && (({1'b0, consec_ff} + 5'h01) >=
			{1'b0, consec_target}); // [RL13]
	end else if (pulse_rise && (pulse_cnt_ff != {`PCNT_W{1'b1}})) begin
		nxt_pulse_cnt = pulse_cnt_ff + 7'h01; // [RL4]
	end
end

// Zone state
always @(posedge aclk) begin
	if (!aresetn) begin
		pulse_cnt_ff <= {`PCNT_W{1'b0}};
		consec_ff <= {`NIBBLE_W{1'b0}};
		fire_ff <= 1'b0;
	end else begin
		pulse_cnt_ff <= nxt_pulse_cnt;
		consec_ff <= nxt_consec;
		fire_ff <= nxt_fire;
	end
end

endmodule
`default_nettype wire

/* flame_pulse_qualifier_properties.sv */
// Concurrent checks on the qualifier's ports.
// Assumes switches change only while aresetn is low.
`timescale 1ns/1ns
`default_nettype none
module flame_pulse_qualifier_properties #(
	parameter int STEP_CYCLES = 3125000
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire logic s_axil_awvalid,
	input wire logic s_axil_awready,
	input wire logic s_axil_wvalid,
	input wire logic s_axil_wready,
	input wire logic [1:0] s_axil_bresp,
	input wire logic s_axil_bvalid,
	input wire logic s_axil_bready,
	input wire logic [5:0] s_axil_araddr,
	input wire logic s_axil_arvalid,
	input wire logic s_axil_arready,
	input wire logic [31:0] s_axil_rdata,
	input wire logic [1:0] s_axil_rresp,
	input wire logic s_axil_rvalid,
	input wire logic s_axil_rready,
	// Switches and detector side
	input wire logic [7:0] zone_enable_sw,
	input wire logic [7:0] flame_pulse,
	input wire logic [7:0] detector_present,
	// Results
	input wire logic [7:0] zone_fire,
	input wire logic [7:0] zone_fault_ff,
	input wire logic [7:0] optical_path_self_test_mask_ff
);
	// Two longest gates must end before a silent zone is judged
	localparam int QUIET_MAX = 512 * STEP_CYCLES + 16;
	int quiet_ff;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// Cycles since the last detector pulse on any zone
	always @(posedge aclk) begin
		if (!aresetn || flame_pulse != 8'h00) begin
			quiet_ff <= 0;
		end else if (quiet_ff != QUIET_MAX) begin
			quiet_ff <= quiet_ff + 1;
		end
	end
	sequence s_write_taken;
		s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready;
	endsequence
	sequence s_read_taken;
		s_axil_arvalid && s_axil_arready;
	endsequence
	chk_b_follows: assert property (s_write_taken |-> ##[1:3] s_axil_bvalid)
		else $error("write response missing");
	chk_b_holds: assert property (s_axil_bvalid && !s_axil_bready |=>
		s_axil_bvalid && $stable(s_axil_bresp)) else $error("bvalid dropped");
	chk_r_follows: assert property (s_read_taken |=> s_axil_rvalid)
		else $error("read data late");
	chk_r_holds: assert property (s_axil_rvalid && !s_axil_rready |=>
		s_axil_rvalid && $stable(s_axil_rdata) && $stable(s_axil_rresp))
		else $error("rvalid dropped");
	chk_ar_blocked: assert property (s_axil_rvalid |-> !s_axil_arready)
		else $error("address taken during read data");
	chk_unmapped_read: assert property (s_read_taken ##0 s_axil_araddr >= 6'h18
		|=> s_axil_rresp == 2'h2 && s_axil_rdata == 32'h0)
		else $error("unmapped read answered");
	chk_fault_present: assert property ($stable(detector_present)[*6] |->
		(zone_fault_ff & detector_present) == 8'h00) else $error("false fault");
	chk_fault_enable: assert property (
		(zone_fault_ff & ~zone_enable_sw) == 8'h00) else $error("disabled fault");
	chk_mask_enable: assert property (
		optical_path_self_test_mask_ff != 8'h00 |->
		optical_path_self_test_mask_ff == zone_enable_sw) else $error("bad mask");
	chk_fire_quiet: assert property (quiet_ff == QUIET_MAX |->
		zone_fire == 8'h00) else $error("fire without pulses");
endmodule
bind flame_pulse_qualifier flame_pulse_qualifier_properties #(
	.STEP_CYCLES(STEP_CYCLES)
) i_props (.aclk(aclk), .aresetn(aresetn), .s_axil_awvalid(s_axil_awvalid),
	.s_axil_awready(s_axil_awready), .s_axil_wvalid(s_axil_wvalid),
	.s_axil_wready(s_axil_wready), .s_axil_bresp(s_axil_bresp),
	.s_axil_bvalid(s_axil_bvalid), .s_axil_bready(s_axil_bready),
	.s_axil_araddr(s_axil_araddr), .s_axil_arvalid(s_axil_arvalid),
	.s_axil_arready(s_axil_arready), .s_axil_rdata(s_axil_rdata),
	.s_axil_rresp(s_axil_rresp), .s_axil_rvalid(s_axil_rvalid),
	.s_axil_rready(s_axil_rready), .zone_enable_sw(zone_enable_sw),
	.flame_pulse(flame_pulse), .detector_present(detector_present),
	.zone_fire(zone_fire), .zone_fault_ff(zone_fault_ff),
	.optical_path_self_test_mask_ff(optical_path_self_test_mask_ff));
`default_nettype wire

/* flame_detector_model.sv */
// Eight remote flame detectors producing pulse trains.
// Assumes pulses are sampled on aclk; high 3 clocks per pulse.
`timescale 1ns/1ns
`default_nettype none
module flame_detector_model (
	// Clock
	input wire logic aclk,
	// Per-zone flame seen by the IR sensor, and its intensity
	input wire logic [7:0] ir_enable,
	input wire logic [7:0] intense,
	// Pulse lines
	output logic [7:0] flame_pulse
);
	logic [3:0] phase_ff [8];
	// Pulse rate rises with intensity; period 6 or 14 clocks
	always @(posedge aclk) begin
		for (int z = 0; z < 8; z++) begin
			if (!ir_enable[z]) begin
				phase_ff[z] <= 4'h0;
				flame_pulse[z] <= 1'b0;
			end else begin
				phase_ff[z] <= (phase_ff[z] == (intense[z] ? 4'h5 : 4'hD)) ?
					4'h0 : phase_ff[z] + 4'h1;
				flame_pulse[z] <= phase_ff[z] < 4'h3;
			end
		end
	end
endmodule
`default_nettype wire

/* flame_pulse_qualifier_tb.sv */
// Self-checking bench for the qualifier: register reads over the bus,
// detector pulse scenarios. Assumes a short STEP_CYCLES of 20.
`timescale 1ns/1ns
`default_nettype none
module flame_pulse_qualifier_tb;
	localparam logic [2:0] F05 = 3'h3;
	localparam logic [2:0] F1 = 3'h4;
	localparam logic [2:0] F2 = 3'h5;
	localparam logic [2:0] F4 = 3'h6;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [5:0] awaddr = 6'h00, araddr = 6'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0, rd;
	logic [3:0] wstrb = 4'hF, count_sw = 4'h0, consec_sw = 4'h0;
	logic [7:0] gate_sw = 8'h00, en_sw = 8'h00, present = 8'h00;
	logic [7:0] ir = 8'h00, intense = 8'h00;
	logic [1:0] rs;
	wire awready, wready, bvalid, arready, rvalid, irq;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [7:0] fire, fault, mask, pulse;
	int n_errors = 0, checks_done = 0, cycles = 0;
	logic [7:0] tg [6] = '{8'h00, 8'h0F, 8'h10, 8'h30, 8'h51, 8'hA0};
	logic [3:0] tc [6] = '{4'h0, 4'h1, 4'h7, 4'hF, 4'h2, 4'h5};
	logic [3:0] tk [6] = '{4'h1, 4'hF, 4'h2, 4'h3, 4'h8, 4'h0};

	flame_pulse_qualifier #(.STEP_CYCLES(22'd20), .FACTOR_0P5S(F05),
		.FACTOR_1S(F1), .FACTOR_2S(F2), .FACTOR_4S(F4)) i_dut (
		.aclk(aclk), .aresetn(aresetn), .s_axil_awaddr(awaddr),
		.s_axil_awvalid(awvalid), .s_axil_awready(awready),
		.s_axil_wdata(wdata), .s_axil_wstrb(wstrb), .s_axil_wvalid(wvalid),
		.s_axil_wready(wready), .s_axil_bresp(bresp), .s_axil_bvalid(bvalid),
		.s_axil_bready(bready), .s_axil_araddr(araddr),
		.s_axil_arvalid(arvalid), .s_axil_arready(arready),
		.s_axil_rdata(rdata), .s_axil_rresp(rresp), .s_axil_rvalid(rvalid),
		.s_axil_rready(rready), .gate_len_sw(gate_sw), .count_sw(count_sw),
		.consec_sw(consec_sw), .zone_enable_sw(en_sw), .flame_pulse(pulse),
		.detector_present(present), .zone_fire(fire), .zone_fault_ff(fault),
		.optical_path_self_test_mask_ff(mask), .irq_ff(irq));
	flame_detector_model i_det (.aclk(aclk), .ir_enable(ir),
		.intense(intense), .flame_pulse(pulse));

	// 100 MHz clock
	always #5 aclk = ~aclk;

	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task print_verdict;
		$display("errors=%0d checks=%0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Bus write; address and data released as each is taken
	task wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		// Late bready on purpose, so the slave must hold its response
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid && !bready) bready <= 1'b1;
		end while (!(bvalid && bready));
		rs = bresp;
		bready <= 1'b0;
	endtask

	task rdr(input logic [5:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		// Late rready on purpose, so read data must stand a cycle
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid && !rready) rready <= 1'b1;
		end while (!(rvalid && rready));
		rd = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask

	// Switches only change under reset; they are captured once after it
	task boot(input logic [7:0] g, input logic [3:0] c, k,
		input logic [7:0] e, p);
		@(posedge aclk);
		aresetn <= 1'b0;
		gate_sw <= g;
		count_sw <= c;
		consec_sw <= k;
		en_sw <= e;
		present <= p;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (12) @(posedge aclk);
	endtask

	function logic [31:0] thr_word(input logic [7:0] g, input logic [3:0] c, k);
		logic [6:0] b;
		logic [2:0] f;
		b = (c < 4'h2) ? 7'h02 : {3'h0, c};
		f = g[7] ? F4 : g[6] ? F2 : g[5] ? F1 : g[4] ? F05 : 3'h1;
		return {20'h0, (k < 4'h2) ? 4'h2 : k, 1'b0, 7'(b * f)};
	endfunction

	task wait_fire(input logic v, input int lim);
		int i;
		i = 0;
		while (fire[0] !== v && i < lim) begin
			@(posedge aclk);
			i++;
		end
		check({31'h0, fire[0]}, {31'h0, v});
	endtask

	// Hang guard
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			print_verdict;
		end
	end

	initial begin
		for (int t = 0; t < 6; t++) begin
			boot(tg[t], tc[t], tk[t], 8'h5A, 8'h0F);
			rdr(6'h04);
			check(rd, {8'h00, 8'h5A, tk[t], tc[t], tg[t]});
			rdr(6'h14);
			check(rd, thr_word(tg[t], tc[t], tk[t]));
		end
		boot(8'h00, 4'h3, 4'h3, 8'hFE, 8'h03);
		check(fault, 8'hFC);
		check(mask, 8'hFE);
		rdr(6'h00);
		check(rd, 32'h1);
		rdr(6'h18);
		check(rs, 2'h2);
		check(rd, 32'h0);
		wr(6'h18, 32'h1);
		check(rs, 2'h2);
		wr(6'h04, 32'hFFFF);
		check(rs, 2'h0);
		rdr(6'h04);
		check(rd, 32'h00FE3300);
		wr(6'h10, 32'h1);
		check(irq, 1'b0);
		intense <= 8'h01;
		// Second pass shows the run count restarts after a failed gate
		for (int r = 0; r < 2; r++) begin
			@(posedge aclk);
			ir <= 8'h03;
			repeat (38) @(posedge aclk);
			check(fire, 8'h00);
			wait_fire(1'b1, 100);
			check(fire, 8'h01);
			repeat (3) @(posedge aclk);
			check(irq, 1'b1);
			rdr(6'h0C);
			check(rd[0], 1'b1);
			rdr(6'h0C);
			check(rd[0], 1'b0);
			repeat (3) @(posedge aclk);
			check(irq, 1'b0);
			@(posedge aclk);
			ir <= 8'h00;
			wait_fire(1'b0, 60);
		end
		// Run bit low holds counters clear, so pulses cannot raise fire
		wr(6'h00, 32'h2);
		ir <= 8'h03;
		repeat (100) @(posedge aclk);
		check(fire, 8'h00);
		rdr(6'h00);
		check(rd, 32'h2);
		ir <= 8'h00;
		wr(6'h00, 32'h1);
		repeat (10300) @(posedge aclk);
		check(fire, 8'h00);
		print_verdict;
	end
endmodule
`default_nettype wire
